/* File: dsc_pkg.sv */
// Package with register indices, field positions, reset values and types for the config block.
package dsc_pkg;

    // ----------------------------------------------------------------
    // Register indices (control space, byte registers).
    // ----------------------------------------------------------------
    localparam logic [5:0] CTL_CFREQ0 = 6'h01;
    localparam logic [5:0] CTL_CHIP0 = 6'h05;
    localparam logic [5:0] CTL_PERIOD_LO = 6'h09;
    localparam logic [5:0] CTL_PERIOD_HI = 6'h0A;
    localparam logic [5:0] CTL_CODE_TYPE = 6'h0B;
    localparam logic [5:0] CTL_POLY1_0 = 6'h0C;
    localparam logic [5:0] CTL_POLY2_0 = 6'h0F;
    localparam logic [5:0] CTL_GOLD_OFS0 = 6'h12;
    localparam logic [5:0] CTL_SYMRATE0 = 6'h15;
    localparam logic [5:0] CTL_SF_LO = 6'h19;
    localparam logic [5:0] CTL_SF_HI = 6'h1A;
    localparam logic [5:0] CTL_MODE = 6'h1B;
    localparam logic [5:0] CTL_BIAS = 6'h1C;
    localparam logic [5:0] CTL_AGC = 6'h1D;
    localparam logic [5:0] CTL_OUTSEL = 6'h20;
    localparam logic [5:0] CTL_IP3 = 6'h29;
    localparam logic [5:0] CTL_IP0 = 6'h2C;
    localparam int CTL_COUNT = 45;

    // ----------------------------------------------------------------
    // Register indices (status space).
    // ----------------------------------------------------------------
    localparam logic [5:0] STS_HWCHK7 = 6'h07;
    localparam logic [5:0] STS_SRATE0 = 6'h08;
    localparam logic [5:0] STS_AGC_LO = 6'h0C;
    localparam logic [5:0] STS_DECIM_LO = 6'h0E;
    localparam logic [5:0] STS_CARR0 = 6'h10;
    localparam logic [5:0] STS_LOCK = 6'h14;
    localparam logic [5:0] STS_POWER_LO = 6'h15;

    // ----------------------------------------------------------------
    // Field positions and codes.
    // ----------------------------------------------------------------
    localparam int MODE_SPEC_INV = 0;
    localparam int MODE_QPSK = 1;
    localparam int MODE_SYNC_WORD = 5;
    localparam int MODE_AGC_BYPASS = 6;
    localparam int MODE_IF_INPUT = 7;
    localparam int BIAS_ENABLE = 0;
    localparam int OUT_TP_ENABLE = 7;
    localparam logic [2:0] CODE_GOLD = 3'h1;
    localparam logic [2:0] CODE_MLS = 3'h2;
    localparam logic [2:0] CODE_BARKER = 3'h3;
    localparam logic [2:0] CODE_SATNAV = 3'h4;
    localparam logic [4:0] AGC_K_MAX = 5'h0E;
    localparam logic [15:0] PERIOD_MIN = 16'h0003;
    localparam logic [10:0] SF_MIN = 11'h003;
    localparam logic [5:0] SAT_MAX = 6'h25;
    localparam logic [7:0] CTL_RESET_VAL = 8'h00;

    // ----------------------------------------------------------------
    // Configuration and status types.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] center_freq;
        logic [31:0] chip_rate;
        logic [15:0] code_period;
        logic [2:0] code_type;
        logic [23:0] poly1;
        logic [23:0] poly2;
        logic [23:0] gold_offset;
        logic [5:0] sat_id;
        logic [31:0] symbol_rate;
        logic [10:0] spread_factor;
        logic spec_inv;
        logic qpsk;
        logic sync_word;
        logic agc_enable;
        logic if_input;
        logic bias_enable;
        logic [4:0] agc_k;
        logic [2:0] out_sel;
        logic tp_enable;
        logic [31:0] ip_addr;
    } dsc_cfg_t;

    typedef struct packed {
        logic [26:0] sample_rate;
        logic [11:0] agc_gain;
        logic [15:0] decim;
        logic [23:0] carrier_ofs;
        logic carrier_lock;
        logic code_lock;
        logic sig_present;
        logic frame_lock;
        logic [15:0] sig_power;
    } dsc_stat_t;

endpackage : dsc_pkg

/* File: dsc_regs.sv */
// Control and status register bank of the spread-spectrum demodulator.
//
// What this block does
// - Centre frequency, signed 32-bit, LSB first.
// - Chip rate, unsigned 32-bit, LSB first.
// - Code period 3 to 65535 truncates code.
// - Code type: Gold, MLS, Barker, satnav.
// - First polynomial is 24-bit tap mask.
// - Second polynomial applies only to Gold.
// - Gold phase offset, 24 bits, LSB first.
// - Satellite number 1 to 37, satnav only.
// - Spreading factor 11 bits, range 3-2047.
// - Spectrum inversion negates Q input only.
// - Flag selects BPSK or QPSK decoding.
// - Sync word search needs transmitter support.
// - Gain loop enabled at 0, bypassed at 1.
// - IF input mode ignores Q input.
// - Bias removal enable bit.
// - Output select routes demodulated data.
// - Sampling rate reported as 27 bits.
// - Carrier offset reported signed 24-bit.
// - Lock flags in bits 0 to 3.
// - Test points driven only when enabled.
// - Reading check byte snapshots multi-byte status.
`timescale 1ns/1ps
module dsc_regs
    import dsc_pkg::*;
#(
    parameter int TP_WIDTH = 10,
    parameter logic [7:0] HW_CHECK_VAL = 8'h5A // Arbitrary value.
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [5:0] addr_i,
    input wire logic sts_sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic apply_o,
    output dsc_cfg_t cfg_o,
    input wire dsc_stat_t stat_i,
    input wire logic chip_tick_i,
    output logic agc_update_o,
    input wire logic signed [11:0] q_in_i,
    output logic signed [11:0] q_cond_o,
    input wire logic [TP_WIDTH-1:0] tp_i,
    output logic [TP_WIDTH-1:0] tp_o,
    output logic [TP_WIDTH-1:0] tp_oe_n_o
);

    // ----------------------------------------------------------------
    // Elaboration checks.
    // ----------------------------------------------------------------
    if (TP_WIDTH < 1 || TP_WIDTH > 32) begin : g_chk
        $error("TP_WIDTH out of range");
    end

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CTL_COUNT-1:0][7:0] ctl;
        dsc_cfg_t active;
        dsc_stat_t snap;
        logic [7:0] rdata;
        logic apply;
        logic [13:0] agc_cnt;
        logic agc_update;
        logic signed [11:0] q_cond;
        logic [TP_WIDTH-1:0] tp;
    } dsc_state_t;

    dsc_state_t st;
    dsc_state_t next_st;
    dsc_cfg_t staged;

    // Gather the byte registers into the staged configuration.
    always_comb begin
        staged = '0;
        staged.center_freq = {st.ctl[CTL_CFREQ0+3], st.ctl[CTL_CFREQ0+2],
                              st.ctl[CTL_CFREQ0+1], st.ctl[CTL_CFREQ0]};
        staged.chip_rate = {st.ctl[CTL_CHIP0+3], st.ctl[CTL_CHIP0+2],
                            st.ctl[CTL_CHIP0+1], st.ctl[CTL_CHIP0]};
        staged.code_period = {st.ctl[CTL_PERIOD_HI], st.ctl[CTL_PERIOD_LO]};
        if (staged.code_period < PERIOD_MIN) begin
            staged.code_period = PERIOD_MIN;
        end
        staged.code_type = st.ctl[CTL_CODE_TYPE][2:0];
        staged.poly1 = {st.ctl[CTL_POLY1_0+2], st.ctl[CTL_POLY1_0+1],
                        st.ctl[CTL_POLY1_0]};
        // Second polynomial and the phase offset matter only for Gold codes.
        if (staged.code_type == CODE_GOLD) begin
            staged.poly2 = {st.ctl[CTL_POLY2_0+2], st.ctl[CTL_POLY2_0+1],
                            st.ctl[CTL_POLY2_0]};
            staged.gold_offset = {st.ctl[CTL_GOLD_OFS0+2], st.ctl[CTL_GOLD_OFS0+1],
                                  st.ctl[CTL_GOLD_OFS0]};
        end
        // Satellite number is used only for satnav codes and only when in range.
        if (staged.code_type == CODE_SATNAV && st.ctl[CTL_GOLD_OFS0][5:0] != 6'h00
                && st.ctl[CTL_GOLD_OFS0][5:0] <= SAT_MAX) begin
            staged.sat_id = st.ctl[CTL_GOLD_OFS0][5:0];
        end
        staged.symbol_rate = {st.ctl[CTL_SYMRATE0+3], st.ctl[CTL_SYMRATE0+2],
                              st.ctl[CTL_SYMRATE0+1], st.ctl[CTL_SYMRATE0]};
        staged.spread_factor = {st.ctl[CTL_SF_HI][2:0], st.ctl[CTL_SF_LO]};
        if (staged.spread_factor < SF_MIN) begin
            staged.spread_factor = SF_MIN;
        end
        staged.spec_inv = st.ctl[CTL_MODE][MODE_SPEC_INV];
        staged.qpsk = st.ctl[CTL_MODE][MODE_QPSK];
        staged.sync_word = st.ctl[CTL_MODE][MODE_SYNC_WORD];
        staged.agc_enable = ~st.ctl[CTL_MODE][MODE_AGC_BYPASS];
        staged.if_input = st.ctl[CTL_MODE][MODE_IF_INPUT];
        staged.bias_enable = st.ctl[CTL_BIAS][BIAS_ENABLE];
        staged.agc_k = st.ctl[CTL_AGC][4:0];
        if (staged.agc_k > AGC_K_MAX) begin
            staged.agc_k = AGC_K_MAX;
        end
        staged.out_sel = st.ctl[CTL_OUTSEL][2:0];
        staged.tp_enable = st.ctl[CTL_OUTSEL][OUT_TP_ENABLE];
        staged.ip_addr = {st.ctl[CTL_IP3], st.ctl[CTL_IP3+1],
                          st.ctl[CTL_IP3+2], st.ctl[CTL_IP0]};
    end

    // ----------------------------------------------------------------
    // Next-state logic.
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.apply = 1'b0;
        next_st.agc_update = 1'b0;
        // Register writes; the last IP byte commits the staged settings.
        if (wr_i && !sts_sel_i && addr_i != 6'h00 && int'(addr_i) < CTL_COUNT) begin
            next_st.ctl[addr_i] = wdata_i;
            if (addr_i == CTL_IP0) begin
                next_st.apply = 1'b1;
            end
        end
        if (st.apply) begin
            next_st.active = staged;
        end
        // Reading the check byte captures all multi-byte status at once.
        if (rd_i && sts_sel_i && addr_i == STS_HWCHK7) begin
            next_st.snap = stat_i;
        end
        // Read data is registered one cycle after the strobe.
        if (rd_i) begin
            next_st.rdata = rd_mux(addr_i, sts_sel_i);
        end
        // Gain update strobe every 2^k chips.
        if (chip_tick_i) begin
            next_st.agc_cnt = st.agc_cnt + 14'h0001;
            if ((st.agc_cnt & agc_mask(st.active.agc_k)) == 14'h0000) begin
                next_st.agc_update = st.active.agc_enable;
            end
        end
        // Q input conditioning: ignored in IF mode, negated under inversion.
        if (st.active.if_input) begin
            next_st.q_cond = 12'sh000;
        end else if (st.active.spec_inv) begin
            next_st.q_cond = -q_in_i;
        end else begin
            next_st.q_cond = q_in_i;
        end
        // Test point data is registered; it clears one cycle after the pins begin to float.
        next_st.tp = st.active.tp_enable ? tp_i : '0;
    end

    // Mask of counter bits that must be zero for an update at exponent k.
    function automatic logic [13:0] agc_mask(input logic [4:0] k);
        logic [13:0] m;
        m = 14'h0000;
        for (int i = 0; i < 14; i++) begin
            if (i < int'(k)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : agc_mask

    // Read multiplexer over control space and status space (snapshot values, live lock flags).
    function automatic logic [7:0] rd_mux(input logic [5:0] a, input logic s);
        logic [7:0] d;
        int o;
        d = 8'h00;
        o = int'(a);
        if (!s) begin
            if (a != 6'h00 && o < CTL_COUNT) begin
                d = st.ctl[a];
            end
        end else begin
            case (a)
                STS_HWCHK7: d = HW_CHECK_VAL;
                STS_SRATE0: d = st.snap.sample_rate[7:0];
                STS_SRATE0 + 6'h01: d = st.snap.sample_rate[15:8];
                STS_SRATE0 + 6'h02: d = st.snap.sample_rate[23:16];
                STS_SRATE0 + 6'h03: d = {5'h00, st.snap.sample_rate[26:24]};
                STS_AGC_LO: d = st.snap.agc_gain[7:0];
                STS_AGC_LO + 6'h01: d = {4'h0, st.snap.agc_gain[11:8]};
                STS_DECIM_LO: d = st.snap.decim[7:0];
                STS_DECIM_LO + 6'h01: d = st.snap.decim[15:8];
                STS_CARR0: d = st.snap.carrier_ofs[7:0];
                STS_CARR0 + 6'h01: d = st.snap.carrier_ofs[15:8];
                STS_CARR0 + 6'h02: d = st.snap.carrier_ofs[23:16];
                STS_LOCK: d = {4'h0, stat_i.frame_lock, stat_i.sig_present,
                               stat_i.code_lock, stat_i.carrier_lock};
                STS_POWER_LO: d = st.snap.sig_power[7:0];
                STS_POWER_LO + 6'h01: d = st.snap.sig_power[15:8];
                default: d = 8'h00;
            endcase
        end
        return d;
    endfunction : rd_mux

    // ----------------------------------------------------------------
    // State register with clock enable.
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    assign rdata_o = st.rdata;
    assign apply_o = st.apply;
    assign cfg_o = st.active;
    assign agc_update_o = st.agc_update;
    assign q_cond_o = st.q_cond;
    // Test points drive only when enabled; low enable means driving.
    assign tp_o = st.tp;
    assign tp_oe_n_o = st.active.tp_enable ? '0 : '1;

endmodule : dsc_regs

/* File: dsc_regs_chk.sv */
// Port checker for the configuration register bank.
`timescale 1ns/1ps
module dsc_regs_chk
    import dsc_pkg::*;
#(
    parameter int TP_WIDTH = 10,
    parameter logic [7:0] HW_CHECK_VAL = 8'h5A // Arbitrary value.
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [5:0] addr_i,
    input wire logic sts_sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic apply_o,
    input wire dsc_cfg_t cfg_o,
    input wire dsc_stat_t stat_i,
    input wire logic chip_tick_i,
    input wire logic agc_update_o,
    input wire logic signed [11:0] q_in_i,
    input wire logic signed [11:0] q_cond_o,
    input wire logic [TP_WIDTH-1:0] tp_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Accepted bus requests that the checks below start from.
    sequence ip_write_s;
        ce_i && wr_i && !sts_sel_i && addr_i == CTL_IP0;
    endsequence
    sequence sts_read_s(logic [5:0] a);
        ce_i && rd_i && sts_sel_i && addr_i == a;
    endsequence

    // Staged settings go live only through the last address byte.
    apply_pulse_a: assert property (ip_write_s |=> apply_o)
        else $error("apply pulse missing");
    // A pulse held over by a frozen clock enable is not a new pulse.
    apply_cause_a: assert property (apply_o && $past(ce_i) |->
        $past(wr_i && !sts_sel_i && addr_i == CTL_IP0)) else $error("apply without write");
    cfg_hold_a: assert property (!apply_o |=> $stable(cfg_o))
        else $error("config changed without apply");
    // Status reads.
    lock_live_a: assert property (sts_read_s(STS_LOCK) |=>
        rdata_o == $past({4'h0, stat_i.frame_lock, stat_i.sig_present, stat_i.code_lock,
        stat_i.carrier_lock})) else $error("lock flags wrong");
    hw_check_a: assert property (sts_read_s(STS_HWCHK7) |=> rdata_o == HW_CHECK_VAL)
        else $error("check byte wrong");
    rdata_hold_a: assert property (!(ce_i && rd_i) |=> $stable(rdata_o))
        else $error("read data moved");
    // Q conditioning path.
    q_pass_a: assert property (ce_i && !cfg_o.if_input && !cfg_o.spec_inv
        |=> q_cond_o == $past(q_in_i)) else $error("q pass wrong");
    q_inv_a: assert property (ce_i && !cfg_o.if_input && cfg_o.spec_inv
        |=> q_cond_o == -$past(q_in_i)) else $error("q invert wrong");
    q_if_a: assert property (ce_i && cfg_o.if_input |=> q_cond_o == 12'h000)
        else $error("q not ignored");
    // Gain update strobe.
    agc_cause_a: assert property (agc_update_o && $past(ce_i) |->
        $past(chip_tick_i && cfg_o.agc_enable)) else $error("stray gain update");
    agc_every_a: assert property (ce_i && chip_tick_i && cfg_o.agc_enable
        && cfg_o.agc_k == 5'h00 |=> agc_update_o) else $error("gain update missing");
    // Test point drivers follow the enable bit.
    tp_drive_a: assert property (cfg_o.tp_enable && $past(cfg_o.tp_enable)
        |-> tp_oe_n_o == '0) else $error("test points not driven");
    tp_float_a: assert property (!cfg_o.tp_enable && !$past(cfg_o.tp_enable)
        |-> tp_oe_n_o == '1) else $error("test points driven");
endmodule : dsc_regs_chk

bind dsc_regs dsc_regs_chk #(.TP_WIDTH(TP_WIDTH), .HW_CHECK_VAL(HW_CHECK_VAL)) chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i), .sts_sel_i(sts_sel_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .apply_o(apply_o), .cfg_o(cfg_o),
    .stat_i(stat_i), .chip_tick_i(chip_tick_i), .agc_update_o(agc_update_o),
    .q_in_i(q_in_i), .q_cond_o(q_cond_o), .tp_oe_n_o(tp_oe_n_o));

/* File: tb.sv */
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module tb import dsc_pkg::*;;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic sts_sel_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic chip_tick_i = 1'b0;
    logic [5:0] addr_i = 6'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic apply_o;
    logic agc_update_o;
    dsc_cfg_t cfg_o;
    dsc_stat_t stat_i = '0;
    logic signed [11:0] q_in_i = 12'h123;
    logic signed [11:0] q_cond_o;
    logic [9:0] tp_i = 10'h2A5;
    logic [9:0] tp_o;
    logic [9:0] tp_oe_n_o;
    int errors = 0;
    int total_checks = 0;
    int pulses = 0;
    int cyc = 0;

    dsc_regs dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i),
        .sts_sel_i(sts_sel_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .apply_o(apply_o), .cfg_o(cfg_o), .stat_i(stat_i), .chip_tick_i(chip_tick_i),
        .agc_update_o(agc_update_o), .q_in_i(q_in_i), .q_cond_o(q_cond_o), .tp_i(tp_i),
        .tp_o(tp_o), .tp_oe_n_o(tp_oe_n_o));

    // The clock toggles every 20 ns, half of its 40 ns period.
    always #20 clk_i = ~clk_i;

    // Gain strobes are counted at the falling edge, once settled; a hung run is cut short.
    always @(negedge clk_i) begin
        cyc++;
        if (agc_update_o === 1'b1) pulses++;
        if (cyc == 3000) begin
            errors++;
            test_done();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Compares a seen value with the expected one.
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : ck

    // One control write; an idle edge comes first and the strobe stands for one edge.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 addr_i = a;
        wdata_i = d;
        sts_sel_i = 1'b0;
        wr_i = 1'b1;
        @(posedge clk_i);
        #1 wr_i = 1'b0;
    endtask : wr

    // One read after an idle edge; data is valid the cycle after the strobe.
    task automatic rd(input logic s, input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_i);
        #1 addr_i = a;
        sts_sel_i = s;
        rd_i = 1'b1;
        @(posedge clk_i);
        #1 rd_i = 1'b0;
        ck(32'(rdata_o), 32'(e));
    endtask : rd

    // Rewrites the last address byte and checks the one-cycle apply pulse.
    task automatic apply();
        wr(CTL_IP0, 8'hAC);
        ck(32'(apply_o), 32'h1);
        @(posedge clk_i);
        #1 ck(32'(apply_o), 32'h0);
    endtask : apply

    // Sets mode and gain response, runs chip ticks, counts strobes.
    task automatic run(input logic [7:0] m, input logic [7:0] k, input int n, input int e);
        wr(CTL_MODE, m);
        wr(CTL_AGC, k);
        apply();
        pulses = 0;
        chip_tick_i = 1'b1;
        repeat (n) @(posedge clk_i);
        #1 chip_tick_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 ck(32'(pulses), 32'(e));
        ck(32'({q_cond_o}), 32'(m[7] ? 12'h000 : (m[0] ? 12'hEDD : 12'h123)));
    endtask : run

    function automatic logic [7:0] pat(input int i);
        return 8'h80 | 8'(i);
    endfunction : pat

    // Main sequence of tests.
    initial begin
        repeat (6) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        ck(32'(tp_oe_n_o), 32'h0000_03FF);
        // The last address byte commits, so it is left to the apply test.
        for (int i = 1; i < 44; i++) begin
            if (i < 30 || i == 32 || i > 40) begin
                rd(1'b0, 6'(i), 8'h00);
                wr(6'(i), pat(i));
                rd(1'b0, 6'(i), pat(i));
            end
        end
        wr(6'h2D, 8'hFF);
        rd(1'b0, 6'h2D, 8'h00);
        ce_i = 1'b0;
        wr(CTL_CFREQ0, 8'h00);
        ce_i = 1'b1;
        rd(1'b0, CTL_CFREQ0, 8'h81);
        ck(cfg_o.center_freq, 32'h0);
        $display("test register access done");
        rd(1'b0, CTL_IP0, 8'h00);
        apply();
        rd(1'b0, CTL_IP0, 8'hAC);
        ck(cfg_o.center_freq, 32'h8483_8281);
        ck(cfg_o.chip_rate, 32'h8887_8685);
        ck(32'(cfg_o.code_period), 32'h0000_8A89);
        ck(32'(cfg_o.poly1), 32'h008E_8D8C);
        ck(cfg_o.symbol_rate, 32'h9897_9695);
        ck(32'(cfg_o.spread_factor), 32'h0000_0299);
        ck(32'({cfg_o.if_input, cfg_o.agc_enable, cfg_o.sync_word, cfg_o.qpsk,
            cfg_o.spec_inv}), 32'h1B);
        ck(32'({cfg_o.bias_enable, cfg_o.agc_k, cfg_o.out_sel, cfg_o.tp_enable}), 32'h0E1);
        ck(cfg_o.ip_addr, 32'hA9AA_ABAC);
        @(posedge clk_i);
        #1 ck(32'(tp_oe_n_o), 32'h0);
        ck(32'(tp_o), 32'(tp_i));
        $display("test apply done");
        for (int j = 1; j < 7; j++) begin
            wr(CTL_OUTSEL, 8'(j));
            wr(CTL_CODE_TYPE, 8'(j));
            apply();
            ck(32'(cfg_o.out_sel), 32'(j));
            ck(32'(cfg_o.code_type), 32'(j));
            ck(32'(cfg_o.poly2), j == 1 ? 32'h0091_908F : 32'h0);
            ck(32'(cfg_o.gold_offset), j == 1 ? 32'h0094_9392 : 32'h0);
            if (j == 4) ck(32'(cfg_o.sat_id), 32'h12);
        end
        wr(CTL_PERIOD_LO, 8'h02);
        wr(CTL_PERIOD_HI, 8'h00);
        wr(CTL_SF_LO, 8'h02);
        wr(CTL_SF_HI, 8'h00);
        wr(CTL_CODE_TYPE, 8'h04);
        wr(CTL_GOLD_OFS0, 8'h26);
        apply();
        ck(32'(cfg_o.code_period), 32'h3);
        ck(32'(cfg_o.spread_factor), 32'h3);
        ck(32'(cfg_o.sat_id), 32'h0);
        ck(32'(tp_oe_n_o), 32'h0000_03FF);
        $display("test codes done");
        run(8'h01, 8'h00, 4, 4);
        run(8'h00, 8'h02, 16, 4);
        run(8'h40, 8'h00, 8, 0);
        run(8'hC1, 8'h0F, 8, 0);
        $display("test gain and q done");
        stat_i.sample_rate = 27'h5AB_CDEF;
        stat_i.carrier_ofs = 24'h12_3456;
        stat_i.agc_gain = 12'hABC;
        stat_i.decim = 16'h1357;
        stat_i.sig_power = 16'h2468;
        rd(1'b1, STS_HWCHK7, 8'h5A);
        stat_i = '0;
        stat_i.carrier_lock = 1'b1;
        stat_i.sig_present = 1'b1;
        rd(1'b1, STS_SRATE0, 8'hEF);
        rd(1'b1, 6'h09, 8'hCD);
        rd(1'b1, 6'h0A, 8'hAB);
        rd(1'b1, 6'h0B, 8'h05);
        rd(1'b1, STS_CARR0, 8'h56);
        rd(1'b1, 6'h11, 8'h34);
        rd(1'b1, 6'h12, 8'h12);
        rd(1'b1, STS_LOCK, 8'h05);
        rd(1'b1, STS_AGC_LO, 8'hBC);
        rd(1'b1, 6'h0D, 8'h0A);
        rd(1'b1, STS_DECIM_LO, 8'h57);
        rd(1'b1, 6'h0F, 8'h13);
        rd(1'b1, STS_POWER_LO, 8'h68);
        rd(1'b1, 6'h16, 8'h24);
        $display("test status done");
        test_done();
    end
endmodule : tb
